//--- prc_top.sv
`timescale 1ns/1ps
`default_nettype none
module prc_top (
   // Clock
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // Request
   input wire logic start,
   input wire logic rgba_mode,
   input wire prc_pkg::prc_fmt_t fmt,
   input wire prc_pkg::prc_type_t out_type,
   input wire prc_pkg::prc_buf_t buf_kind,
   input wire prc_pkg::prc_clamp_t read_clamp,
   input wire logic depth_is_float,
   input wire logic [5:0] depth_bits,
   input wire logic [2:0] base_has_gba,
   input wire logic [31:0] output_buffer_bound_id,
   input wire logic [31:0] data_addr,
   input wire logic [31:0] buf_size,
   input wire logic [15:0] width,
   input wire logic [15:0] height,
   input wire logic [15:0] pack_row_length,
   input wire logic [15:0] pack_skip_rows,
   input wire logic [15:0] pack_skip_pixels,
   input wire logic [3:0] pack_alignment,
   input wire logic err_clear,
   // Framebuffer pixel stream
   input wire logic px_valid,
   output logic px_ready,
   input wire logic [31:0] px_r,
   input wire logic [31:0] px_g,
   input wire logic [31:0] px_b,
   input wire logic [31:0] px_a,
   // Memory write stream
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_be,
   output logic wr_to_buffer,
   // Status
   output logic busy_ff,
   output logic done_ff,
   output prc_pkg::prc_err_t err_ff
);
   prc_pkg::prc_state_t st_ff;
   logic [15:0] i_ff, j_ff;
   logic [1:0] el_ff;
   logic [2:0] bpe, nel;
   logic [31:0] stride, row_bytes, total, grp_addr;
   logic clamp_on, is_fixed, lum;
   logic [31:0] r, g, b, a, comp, fcl, nrm, word;
   logic [5:0] bits;
   logic sgn;
   logic in_ready, out_valid;
   logic [67:0] out_data;
   logic [31:0] elem [4];

   function automatic logic [2:0] type_bytes(input prc_pkg::prc_type_t t);
      case (t)
         prc_pkg::TY_UBYTE, prc_pkg::TY_BYTE, prc_pkg::TY_ONE_BIT: type_bytes = 3'd1;
         prc_pkg::TY_USHORT, prc_pkg::TY_SHORT, prc_pkg::TY_HALF,
         prc_pkg::TY_565: type_bytes = 3'd2;
         default: type_bytes = 3'd4;
      endcase
   endfunction

   function automatic logic [2:0] fmt_elems(input prc_pkg::prc_fmt_t f);
      case (f)
         prc_pkg::FMT_RG, prc_pkg::FMT_LUM_ALPHA: fmt_elems = 3'd2;
         prc_pkg::FMT_RGB, prc_pkg::FMT_BGR: fmt_elems = 3'd3;
         prc_pkg::FMT_RGBA, prc_pkg::FMT_BGRA: fmt_elems = 3'd4;
         default: fmt_elems = 3'd1;
      endcase
   endfunction

   // Same-sign float add, truncating
   function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
      logic [31:0] hi, lo;
      logic [24:0] ms;
      hi = (x[30:0] >= y[30:0]) ? x : y;
      lo = (x[30:0] >= y[30:0]) ? y : x;
      ms = {2'b01, hi[22:0]} + (({2'b01, lo[22:0]} >> (hi[30:23] - lo[30:23])) &
           {25{lo[30:23] != 8'h0}});
      if (hi[30:23] == 8'h0) fadd = prc_pkg::ZERO_F32;
      else if (ms[24]) fadd = {hi[31], hi[30:23] + 8'h01, ms[23:1]};
      else fadd = {hi[31], hi[30:23], ms[22:0]};
   endfunction

   // Unsigned m-bit fraction to float; all ones is exactly one
   function automatic logic [31:0] frac2f(input logic [31:0] v, input logic [5:0] m);
      logic [63:0] t;
      int p;
      p = -1;
      for (int k = 0; k < 32; k++) begin
         if (v[k]) p = k;
      end
      t = {32'h0, v} << (55 - p);
      if (p < 0) frac2f = prc_pkg::ZERO_F32;
      else if (v == 32'((64'h1 << m) - 64'h1)) frac2f = prc_pkg::ONE_F32;
      else frac2f = {1'b0, 8'(127 - int'(m) + p), t[54:32]};
   endfunction

   // Group geometry from pack settings
   always_comb begin
      bpe = type_bytes(out_type);
      nel = (out_type inside {prc_pkg::TY_565, prc_pkg::TY_8888,
             prc_pkg::TY_PACKED_SMALL_FLOAT_RGB, prc_pkg::TY_24_8}) ? 3'd1 : fmt_elems(fmt);
      row_bytes = 32'((pack_row_length != 16'h0) ? pack_row_length : width) * 32'(nel)
                  * 32'(bpe);
      stride = (row_bytes + 32'(pack_alignment) - 32'h1) & ~(32'(pack_alignment) - 32'h1);
      total = (32'(pack_skip_rows) + 32'(height) - 32'h1) * stride
              + (32'(pack_skip_pixels) + 32'(width)) * 32'(nel) * 32'(bpe);
      grp_addr = data_addr + (32'(pack_skip_rows) + 32'(j_ff)) * stride
                 + (32'(pack_skip_pixels) + 32'(i_ff)) * 32'(nel) * 32'(bpe)
                 + 32'(el_ff) * 32'(bpe);
   end

   // Component selection and luminance
   always_comb begin
      is_fixed = (buf_kind == prc_pkg::BUF_UNORM) || (buf_kind == prc_pkg::BUF_SNORM);
      clamp_on = (read_clamp == prc_pkg::CLAMP_TRUE) ||
                 (read_clamp == prc_pkg::CLAMP_FIXED_ONLY && is_fixed);
      r = px_r;
      g = base_has_gba[0] ? px_g : prc_pkg::ZERO_F32;
      b = base_has_gba[1] ? px_b : prc_pkg::ZERO_F32;
      a = base_has_gba[2] ? px_a : prc_pkg::ONE_F32;
      lum = rgba_mode && (fmt inside {prc_pkg::FMT_LUM, prc_pkg::FMT_LUM_ALPHA});
      // Upstream delivers unorm/snorm as float already, depth as m-bit fraction
      elem[0] = lum ? fadd(fadd(r, g), b) : r;
      elem[1] = (fmt == prc_pkg::FMT_LUM_ALPHA) ? a : g;
      elem[2] = b;
      elem[3] = a;
      if (fmt == prc_pkg::FMT_BGR || fmt == prc_pkg::FMT_BGRA) begin
         elem[0] = b;
         elem[2] = r;
      end
      case (fmt)
         prc_pkg::FMT_GREEN: elem[0] = g;
         prc_pkg::FMT_BLUE: elem[0] = b;
         prc_pkg::FMT_ALPHA: elem[0] = a;
         default: ;
      endcase
      comp = elem[el_ff];
   end

   always_comb begin
      case (out_type)
         prc_pkg::TY_UBYTE, prc_pkg::TY_BYTE: bits = 6'd8;
         prc_pkg::TY_USHORT, prc_pkg::TY_SHORT: bits = 6'd16;
         prc_pkg::TY_24_8: bits = 6'd24;
         default: bits = 6'd32;
      endcase
      sgn = out_type inside {prc_pkg::TY_BYTE, prc_pkg::TY_SHORT, prc_pkg::TY_INT};
   end

   prc_conv u_conv (
      .f_in(comp),
      .clamp_en((out_type inside {prc_pkg::TY_FLOAT, prc_pkg::TY_HALF,
                 prc_pkg::TY_PACKED_SMALL_FLOAT_RGB}) ? clamp_on : 1'b1),
      .clamp_neg(buf_kind == prc_pkg::BUF_SNORM && !clamp_on && sgn),
      .bits(bits),
      .sgn(sgn),
      .f_clamped(fcl),
      .norm(nrm)
   );

   // Final per-type word
   always_comb begin
      word = nrm;
      if (fmt == prc_pkg::FMT_INDEX) begin
         case (out_type)
            prc_pkg::TY_UBYTE, prc_pkg::TY_24_8, prc_pkg::TY_F32_24_8: word = px_r & 32'h0000_00ff;
            prc_pkg::TY_BYTE: word = px_r & 32'h0000_007f;
            prc_pkg::TY_ONE_BIT: word = px_r & 32'h0000_0001;
            prc_pkg::TY_USHORT: word = px_r & 32'h0000_ffff;
            prc_pkg::TY_SHORT: word = px_r & 32'h0000_7fff;
            prc_pkg::TY_INT: word = px_r & 32'h7fff_ffff;
            prc_pkg::TY_FLOAT, prc_pkg::TY_HALF: word = frac2f(px_r, 6'd0);
            default: word = px_r;
         endcase
      end else if (fmt == prc_pkg::FMT_DEPTH || fmt == prc_pkg::FMT_DEPTH_STENCIL) begin
         word = depth_is_float ? px_r : frac2f(px_r, depth_bits);
      end else if (buf_kind == prc_pkg::BUF_INT) begin
         if (sgn) begin
            if ($signed(px_r) > $signed((32'h1 << (bits - 6'd1)) - 32'h1))
               word = (32'h1 << (bits - 6'd1)) - 32'h1;
            else if ($signed(px_r) < -$signed(32'h1 << (bits - 6'd1)))
               word = 32'h0 - (32'h1 << (bits - 6'd1));
            else
               word = px_r;
         end else begin
            word = (bits != 6'd32 && px_r >= (32'h1 << bits)) ? (32'h1 << bits) - 32'h1 : px_r;
         end
      end else if (out_type == prc_pkg::TY_FLOAT) begin
         word = fcl;
      end else if (out_type == prc_pkg::TY_HALF) begin
         word = {16'h0, fcl[31], 5'(fcl[30:23] - 8'd112), fcl[22:13]};
         if (fcl[30:23] < 8'd113) word = {16'h0, fcl[31], 15'h0};
         else if (fcl[30:23] > 8'd142) word = {16'h0, fcl[31], 15'h7c00};
      end else if (out_type == prc_pkg::TY_PACKED_SMALL_FLOAT_RGB) begin
         word = {fcl[27:18], fcl[27:17], fcl[27:17]};
      end
   end

   // Sequencer
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_ff <= prc_pkg::ST_IDLE;
         i_ff <= 16'h0;
         j_ff <= 16'h0;
         el_ff <= 2'h0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (ce) begin
         done_ff <= 1'b0;
         case (st_ff)
            prc_pkg::ST_IDLE: begin
               if (start) begin
                  i_ff <= 16'h0;
                  j_ff <= 16'h0;
                  el_ff <= 2'h0;
                  if (output_buffer_bound_id != 32'h0 &&
                      ((data_addr % 32'(bpe)) != 32'h0 || data_addr + total > buf_size))
                     done_ff <= 1'b1;
                  else if (width != 16'h0 && height != 16'h0) begin
                     st_ff <= prc_pkg::ST_RUN;
                     busy_ff <= 1'b1;
                  end else
                     done_ff <= 1'b1;
               end
            end
            prc_pkg::ST_RUN: begin
               if (px_valid && in_ready) begin
                  if (el_ff != 2'(nel - 3'd1)) el_ff <= el_ff + 2'h1;
                  else begin
                     el_ff <= 2'h0;
                     if (i_ff != width - 16'h1) i_ff <= i_ff + 16'h1;
                     else begin
                        i_ff <= 16'h0;
                        if (j_ff != height - 16'h1) j_ff <= j_ff + 16'h1;
                        else st_ff <= prc_pkg::ST_DONE;
                     end
                  end
               end
            end
            prc_pkg::ST_DONE: begin
               st_ff <= prc_pkg::ST_IDLE;
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end
            default: st_ff <= prc_pkg::ST_IDLE;
         endcase
      end
   end

   // Sticky error; set wins over clear
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         err_ff <= prc_pkg::ERR_NONE;
      end else if (ce) begin
         if (st_ff == prc_pkg::ST_IDLE && start && output_buffer_bound_id != 32'h0 &&
             ((data_addr % 32'(bpe)) != 32'h0 || data_addr + total > buf_size))
            err_ff <= prc_pkg::ERR_INVALID_OP;
         else if (err_clear)
            err_ff <= prc_pkg::ERR_NONE;
      end
   end

   assign px_ready = (st_ff == prc_pkg::ST_RUN) && in_ready && (el_ff == 2'(nel - 3'd1));

   prc_skid #(.W(68)) u_buf (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .in_valid((st_ff == prc_pkg::ST_RUN) && px_valid),
      .in_ready(in_ready),
      .in_data({bpe == 3'd1 ? 4'h1 : (bpe == 3'd2 ? 4'h3 : 4'hf), grp_addr, word}),
      .out_valid(out_valid),
      .out_ready(!wr_valid || wr_ready),
      .out_data(out_data)
   );

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wr_valid <= 1'b0;
         wr_addr <= prc_pkg::RST_WORD;
         wr_data <= prc_pkg::RST_WORD;
         wr_be <= 4'h0;
         wr_to_buffer <= 1'b0;
      end else if (ce) begin
         if (!wr_valid || wr_ready) begin
            wr_valid <= out_valid;
            wr_data <= out_data[31:0];
            wr_addr <= out_data[63:32];
            wr_be <= out_data[67:64];
            wr_to_buffer <= (output_buffer_bound_id != 32'h0);
         end
      end
   end

   a_err_no_run: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(err_ff == prc_pkg::ERR_INVALID_OP) |-> st_ff == prc_pkg::ST_IDLE)
      else $error("error with run");
   a_err_sticky: assert property (@(posedge clock) disable iff (!rst_b)
      (err_ff != prc_pkg::ERR_NONE && !err_clear) |=> err_ff != prc_pkg::ERR_NONE)
      else $error("error not sticky");
   a_wr_hold: assert property (@(posedge clock) disable iff (!rst_b)
      (wr_valid && !wr_ready && ce) |=> wr_valid && $stable(wr_data) && $stable(wr_addr))
      else $error("write dropped");
   a_one_elem: assert property (@(posedge clock) disable iff (!rst_b)
      (nel == 3'd1) |-> el_ff == 2'h0) else $error("extra element");
   a_clamp_true: assert property (@(posedge clock) disable iff (!rst_b)
      read_clamp == prc_pkg::CLAMP_TRUE |-> clamp_on) else $error("clamp off");
   a_clamp_fixed: assert property (@(posedge clock) disable iff (!rst_b)
      (read_clamp == prc_pkg::CLAMP_FIXED_ONLY && buf_kind == prc_pkg::BUF_FLOAT) |-> !clamp_on)
      else $error("clamp on float");
   a_idx_byte: assert property (@(posedge clock) disable iff (!rst_b)
      (fmt == prc_pkg::FMT_INDEX && out_type == prc_pkg::TY_BYTE) |-> word[31:7] == 25'h0)
      else $error("index mask");
   a_alpha_one: assert property (@(posedge clock) disable iff (!rst_b)
      !base_has_gba[2] |-> a == prc_pkg::ONE_F32) else $error("alpha fill");
   c_write: cover property (@(posedge clock) wr_valid && wr_ready);
   c_error: cover property (@(posedge clock) err_ff == prc_pkg::ERR_INVALID_OP);
   c_stall: cover property (@(posedge clock) wr_valid && !wr_ready ##1 wr_valid);
endmodule
`default_nettype wire

//--- prc_pkg.sv
package prc_pkg;
   // Output formats
   typedef enum logic [3:0] {
      FMT_RGBA = 4'h0, FMT_RGB = 4'h1, FMT_BGR = 4'h2, FMT_BGRA = 4'h3,
      FMT_RG = 4'h4, FMT_RED = 4'h5, FMT_GREEN = 4'h6, FMT_BLUE = 4'h7,
      FMT_ALPHA = 4'h8, FMT_LUM = 4'h9, FMT_LUM_ALPHA = 4'ha, FMT_INDEX = 4'hb,
      FMT_DEPTH = 4'hc, FMT_DEPTH_STENCIL = 4'hd, FMT_STENCIL = 4'he
   } prc_fmt_t;
   // Output types
   typedef enum logic [3:0] {
      TY_UBYTE = 4'h0, TY_BYTE = 4'h1, TY_USHORT = 4'h2, TY_SHORT = 4'h3,
      TY_UINT = 4'h4, TY_INT = 4'h5, TY_HALF = 4'h6, TY_FLOAT = 4'h7,
      TY_565 = 4'h8, TY_8888 = 4'h9, TY_24_8 = 4'ha, TY_F32_24_8 = 4'hb,
      TY_ONE_BIT = 4'hc, TY_PACKED_SMALL_FLOAT_RGB = 4'hd
   } prc_type_t;
   // Color buffer kinds
   typedef enum logic [1:0] {
      BUF_UNORM = 2'h0, BUF_SNORM = 2'h1, BUF_INT = 2'h2, BUF_FLOAT = 2'h3
   } prc_buf_t;
   // Read clamp setting
   typedef enum logic [1:0] {
      CLAMP_FALSE = 2'h0, CLAMP_TRUE = 2'h1, CLAMP_FIXED_ONLY = 2'h2
   } prc_clamp_t;
   // Error codes
   typedef enum logic [1:0] {
      ERR_NONE = 2'h0, ERR_INVALID_OP = 2'h1
   } prc_err_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_DONE = 2'b10
   } prc_state_t;
   localparam logic [31:0] ONE_F32 = 32'h3f80_0000;
   localparam logic [31:0] NEG_ONE_F32 = 32'hbf80_0000;
   localparam logic [31:0] ZERO_F32 = 32'h0000_0000;
   localparam int BUF_DEPTH = 2;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

//--- prc_skid.sv
`timescale 1ns/1ps
`default_nettype none
module prc_skid #(
   parameter int W = 64
) (
   // Clock
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_ff [prc_pkg::BUF_DEPTH];
   logic wr_ff, rd_ff;
   logic [1:0] cnt_ff;
   logic push, pop;
   assign in_ready = (cnt_ff != 2'(prc_pkg::BUF_DEPTH));
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data = mem_ff[rd_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else if (ce) begin
         if (push) begin
            mem_ff[wr_ff] <= in_data;
            wr_ff <= ~wr_ff;
         end
         if (pop) begin
            rd_ff <= ~rd_ff;
         end
         cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
      end
   end
   a_skid_no_overflow: assert property (@(posedge clock) disable iff (!rst_b)
      cnt_ff <= 2'(prc_pkg::BUF_DEPTH)) else $error("buffer overflow");
   c_skid_full: cover property (@(posedge clock) disable iff (!rst_b) !in_ready);
endmodule
`default_nettype wire

//--- prc_conv.sv
`timescale 1ns/1ps
`default_nettype none
// Per-component float clamp and conversion to the output field
module prc_conv (
   input wire logic [31:0] f_in,
   input wire logic clamp_en,
   input wire logic clamp_neg,
   input wire logic [5:0] bits,
   input wire logic sgn,
   output logic [31:0] f_clamped,
   output logic [31:0] norm
);
   logic neg;
   logic [7:0] ex;
   logic [23:0] man;
   logic [63:0] prod;
   logic [31:0] maxv;
   logic [31:0] mag;
   int sh;
   always_comb begin
      f_clamped = f_in;
      neg = f_in[31];
      if (clamp_en) begin
         if (neg && !clamp_neg && f_in[30:0] != 31'h0) f_clamped = prc_pkg::ZERO_F32;
         else if (neg && f_in[30:23] >= 8'd127) f_clamped = prc_pkg::NEG_ONE_F32;
         else if (!neg && f_in[30:23] >= 8'd127) f_clamped = prc_pkg::ONE_F32;
      end
      ex = f_clamped[30:23];
      man = {1'b1, f_clamped[22:0]};
      // Unsigned: f*(2^b-1); signed: f*(2^(b-1)-1)
      maxv = sgn ? ((32'h1 << (bits - 6'd1)) - 32'h1) : ((bits == 6'd32) ? 32'hffff_ffff
             : ((32'h1 << bits) - 32'h1));
      prod = {32'h0, maxv} * {40'h0, man};
      sh = 150 - int'(ex);
      if (ex == 8'h0 || sh > 63) mag = 32'h0;
      else mag = 32'((prod + (64'h1 << (sh - 1))) >> sh);
      norm = (f_clamped[31] && sgn) ? (32'h0 - mag) : mag;
   end
endmodule
`default_nettype wire

//--- prc_fb_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Pixel source and write sink on the far side of the converter
module prc_fb_mem (
   // Clock
   input wire logic clock,
   input wire logic rst_b,
   // Bench control
   input wire logic load,
   input wire logic [7:0] groups,
   input wire logic hold,
   input wire logic slow,
   input wire logic [127:0] src,
   // Pixel stream
   output logic px_valid,
   input wire logic px_ready,
   output logic [127:0] px,
   // Write sink
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [31:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_to_buffer
);
   logic [7:0] left_ff;
   logic tog_ff;
   logic [31:0] addr_q[$];
   logic [31:0] data_q[$];
   logic tob_q[$];
   // Idle pixel lines invert every cycle, starting with the inverse of the last group
   always @(posedge clock) begin
      if (!rst_b) begin
         left_ff = 8'h00;
         tog_ff = 1'b0;
         px <= #1 '0;
      end else begin
         if (px_valid && px_ready) left_ff = left_ff - 8'h01;
         if (load) left_ff = groups;
         if (wr_valid && wr_ready) begin
            addr_q.push_back(wr_addr);
            data_q.push_back(wr_data);
            tob_q.push_back(wr_to_buffer);
         end
         tog_ff = !tog_ff;
         px <= #1 (left_ff != 8'h00) ? src : ~px;
      end
      px_valid <= #1 (left_ff != 8'h00);
      wr_ready <= #1 rst_b && !hold && (!slow || tog_ff);
   end
endmodule
`default_nettype wire

//--- pixel_readback_converter_test.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_readback_converter_test;
   logic clock, rst_b, ce, start, rgba_mode, depth_is_float, err_clear, load, hold, slow;
   prc_pkg::prc_fmt_t fmt;
   prc_pkg::prc_type_t out_type;
   prc_pkg::prc_buf_t buf_kind;
   prc_pkg::prc_clamp_t read_clamp;
   prc_pkg::prc_err_t err_ff;
   logic [5:0] depth_bits;
   logic [2:0] base_has_gba;
   logic [31:0] bound_id, data_addr, buf_size, wr_addr, wr_data;
   logic [15:0] width, height, row_len, skip_rows, skip_px;
   logic [3:0] align;
   logic [7:0] groups;
   logic [127:0] src, px;
   logic px_valid, px_ready, wr_valid, wr_ready, wr_to_buffer, busy_ff, done_ff;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   prc_top prc_top_inst (.clock(clock), .rst_b(rst_b), .ce(ce), .start(start),
      .rgba_mode(rgba_mode), .fmt(fmt), .out_type(out_type), .buf_kind(buf_kind),
      .read_clamp(read_clamp), .depth_is_float(depth_is_float), .depth_bits(depth_bits),
      .base_has_gba(base_has_gba), .output_buffer_bound_id(bound_id), .data_addr(data_addr),
      .buf_size(buf_size), .width(width), .height(height), .pack_row_length(row_len),
      .pack_skip_rows(skip_rows), .pack_skip_pixels(skip_px), .pack_alignment(align),
      .err_clear(err_clear), .px_valid(px_valid), .px_ready(px_ready), .px_r(px[31:0]),
      .px_g(px[63:32]), .px_b(px[95:64]), .px_a(px[127:96]), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(),
      .wr_to_buffer(wr_to_buffer), .busy_ff(busy_ff), .done_ff(done_ff), .err_ff(err_ff));

   prc_fb_mem prc_fb_mem_inst (.clock(clock), .rst_b(rst_b), .load(load), .groups(groups),
      .hold(hold), .slow(slow), .src(src), .px_valid(px_valid), .px_ready(px_ready), .px(px),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_to_buffer(wr_to_buffer));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic int nw();
      return prc_fb_mem_inst.data_q.size();
   endfunction

   task automatic dflt;
      rgba_mode = 1'b1;
      fmt = prc_pkg::FMT_RED;
      out_type = prc_pkg::TY_FLOAT;
      buf_kind = prc_pkg::BUF_FLOAT;
      read_clamp = prc_pkg::CLAMP_FALSE;
      depth_is_float = 1'b0;
      depth_bits = 6'h18;
      base_has_gba = 3'h7;
      bound_id = 32'h0000_0000;
      data_addr = 32'h0000_0100;
      buf_size = 32'h0000_1000;
      width = 16'h0001;
      height = 16'h0001;
      row_len = 16'h0000;
      skip_rows = 16'h0000;
      skip_px = 16'h0000;
      align = 4'h4;
      err_clear = 1'b0;
      hold = 1'b0;
      slow = 1'b0;
      src = {4{32'h3f00_0000}};
   endtask

   task automatic go(input int n);
      prc_fb_mem_inst.addr_q.delete();
      prc_fb_mem_inst.data_q.delete();
      prc_fb_mem_inst.tob_q.delete();
      start = 1'b1;
      load = 1'b1;
      groups = 8'(n);
      tick(1);
      start = 1'b0;
      load = 1'b0;
   endtask

   task automatic finish_req;
      int k;
      k = 0;
      while (done_ff !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
      check(32'(done_ff), 32'h1);
      tick(8);
   endtask

   task automatic run(input int n);
      go(n);
      finish_req();
   endtask

   // Codes: output type, buffer kind, clamp; one pixel, low lane compared
   task automatic conv(input logic [3:0] ty, input logic [1:0] bk, input logic [1:0] cl,
         input logic [31:0] r, input logic [31:0] exp);
      logic [31:0] mask;
      out_type = prc_pkg::prc_type_t'(ty);
      buf_kind = prc_pkg::prc_buf_t'(bk);
      read_clamp = prc_pkg::prc_clamp_t'(cl);
      src[31:0] = r;
      mask = (ty < 4'h2) ? 32'h0000_00ff : (ty < 4'h4 || ty == 4'h6) ? 32'h0000_ffff : '1;
      run(1);
      check(32'(nw()), 32'h1);
      check(prc_fb_mem_inst.data_q[0] & mask, exp);
   endtask

   task automatic t_color;
      dflt();
      conv(4'h7, 2'h3, 2'h0, 32'h4000_0000, 32'h4000_0000);
      check(prc_fb_mem_inst.addr_q[0], 32'h0000_0100);
      check(32'(prc_fb_mem_inst.tob_q[0]), 32'h0);
      conv(4'h7, 2'h3, 2'h1, 32'h4000_0000, 32'h3f80_0000);
      conv(4'h6, 2'h3, 2'h1, 32'h4000_0000, 32'h0000_3c00);
      conv(4'h7, 2'h3, 2'h2, 32'h4000_0000, 32'h4000_0000);
      conv(4'h7, 2'h0, 2'h2, 32'h4000_0000, 32'h3f80_0000);
      conv(4'h0, 2'h3, 2'h0, 32'h4000_0000, 32'h0000_00ff);
      conv(4'h0, 2'h3, 2'h0, 32'hbf80_0000, 32'h0000_0000);
      conv(4'h3, 2'h3, 2'h0, 32'h3f80_0000, 32'h0000_7fff);
      conv(4'h1, 2'h1, 2'h0, 32'hc000_0000, 32'h0000_0081);
      conv(4'h1, 2'h1, 2'h1, 32'hc000_0000, 32'h0000_0000);
      conv(4'h0, 2'h1, 2'h0, 32'hc000_0000, 32'h0000_0000);
      conv(4'h0, 2'h2, 2'h0, 32'h0000_012c, 32'h0000_00ff);
      conv(4'h1, 2'h2, 2'h0, 32'h0000_012c, 32'h0000_007f);
      $display("color conversion test done");
   endtask

   task automatic t_fmts;
      logic [3:0] fl [9];
      int cnt [9];
      fl = '{4'h5, 4'h6, 4'h8, 4'h4, 4'h1, 4'h2, 4'h0, 4'h3, 4'ha};
      cnt = '{1, 1, 1, 2, 3, 3, 4, 4, 2};
      dflt();
      src = {32'h3f00_0000, {3{32'h3e80_0000}}};
      for (int k = 0; k < 9; k++) begin
         fmt = prc_pkg::prc_fmt_t'(fl[k]);
         run(1);
         check(32'(nw()), 32'(cnt[k]));
      end
      check(prc_fb_mem_inst.data_q[0], 32'h3f40_0000);
      check(prc_fb_mem_inst.data_q[1], 32'h3f00_0000);
      fmt = prc_pkg::FMT_LUM;
      run(1);
      check(32'(nw()), 32'h1);
      check(prc_fb_mem_inst.data_q[0], 32'h3f40_0000);
      fmt = prc_pkg::FMT_RGB;
      out_type = prc_pkg::TY_PACKED_SMALL_FLOAT_RGB;
      run(1);
      check(32'(nw()), 32'h1);
      $display("format test done");
   endtask

   task automatic t_stall;
      dflt();
      fmt = prc_pkg::FMT_RGBA;
      width = 16'h0004;
      base_has_gba = 3'h0;
      hold = 1'b1;
      go(4);
      tick(20);
      check(32'(px_ready), 32'h0);
      check(32'(wr_valid), 32'h1);
      start = 1'b1;
      tick(1);
      start = 1'b0;
      hold = 1'b0;
      slow = 1'b1;
      finish_req();
      check(32'(busy_ff), 32'h0);
      check(32'(nw()), 32'd16);
      for (int k = 0; k < 16; k++) begin
         check(prc_fb_mem_inst.addr_q[k], 32'h0000_0100 + 32'(4 * k));
         check(prc_fb_mem_inst.data_q[k], (k % 4 == 0) ? 32'h3f00_0000 :
            (k % 4 == 3) ? 32'h3f80_0000 : 32'h0000_0000);
      end
      $display("stall test done");
   endtask

   task automatic t_place;
      dflt();
      width = 16'h0002;
      height = 16'h0002;
      row_len = 16'h0003;
      skip_rows = 16'h0001;
      skip_px = 16'h0001;
      run(4);
      for (int k = 0; k < 4; k++) begin
         check(prc_fb_mem_inst.addr_q[k], 32'(256 + (1 + k / 2) * 12 + (1 + k % 2) * 4));
      end
      $display("placement test done");
   endtask

   task automatic t_index_depth;
      dflt();
      rgba_mode = 1'b0;
      fmt = prc_pkg::FMT_INDEX;
      conv(4'h0, 2'h2, 2'h0, 32'h0000_01ff, 32'h0000_00ff);
      conv(4'h1, 2'h2, 2'h0, 32'h0000_01ff, 32'h0000_007f);
      conv(4'h2, 2'h2, 2'h0, 32'h0001_ffff, 32'h0000_ffff);
      conv(4'h3, 2'h2, 2'h0, 32'h0001_ffff, 32'h0000_7fff);
      conv(4'h7, 2'h2, 2'h0, 32'h0000_0003, 32'h4040_0000);
      dflt();
      fmt = prc_pkg::FMT_DEPTH;
      conv(4'h7, 2'h0, 2'h0, 32'h00ff_ffff, 32'h3f80_0000);
      depth_bits = 6'h10;
      conv(4'h7, 2'h0, 2'h0, 32'h0000_ffff, 32'h3f80_0000);
      depth_is_float = 1'b1;
      conv(4'h7, 2'h0, 2'h0, 32'h3f00_0000, 32'h3f00_0000);
      $display("index and depth test done");
   endtask

   task automatic t_err;
      dflt();
      bound_id = 32'h0000_0001;
      out_type = prc_pkg::TY_USHORT;
      data_addr = 32'h0000_0101;
      run(0);
      check(32'(err_ff), 32'h1);
      check(32'(nw()), 32'h0);
      bound_id = 32'h0000_0000;
      run(1);
      check(32'(err_ff), 32'h1);
      check(32'(nw()), 32'h1);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      tick(1);
      check(32'(err_ff), 32'h0);
      bound_id = 32'h0000_0001;
      out_type = prc_pkg::TY_UBYTE;
      run(1);
      check(32'(err_ff), 32'h0);
      check(32'(prc_fb_mem_inst.tob_q[0]), 32'h1);
      out_type = prc_pkg::TY_FLOAT;
      data_addr = 32'h0000_0010;
      buf_size = 32'h0000_0010;
      run(0);
      check(32'(err_ff), 32'h1);
      check(32'(nw()), 32'h0);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      buf_size = 32'h0000_0014;
      run(1);
      check(32'(err_ff), 32'h0);
      check(prc_fb_mem_inst.addr_q[0], 32'h0000_0010);
      $display("error test done");
   endtask

   initial begin
      ce = 1'b1;
      start = 1'b0;
      load = 1'b0;
      groups = 8'h00;
      rst_b = 1'b0;
      dflt();
      tick(4);
      rst_b = 1'b1;
      tick(1);
      check({29'h0, busy_ff, done_ff, wr_valid}, 32'h0);
      check(32'(err_ff), 32'h0);
      t_color();
      t_fmts();
      t_stall();
      t_place();
      t_index_depth();
      t_err();
      report_and_stop();
   end
endmodule
`default_nettype wire
